// [core/ir_carrier_modulator.sv]
`timescale 1ns/1ps

module ir_carrier_modulator (
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_sys_rst,
    // axi4-lite write address
    input  wire logic [7:0]  i_s_axi_awaddr,
    input  wire logic        i_s_axi_awvalid,
    output logic             o_s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] i_s_axi_wdata,
    input  wire logic [3:0]  i_s_axi_wstrb,
    input  wire logic        i_s_axi_wvalid,
    output logic             o_s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       o_s_axi_bresp,
    output logic             o_s_axi_bvalid,
    input  wire logic        i_s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  i_s_axi_araddr,
    input  wire logic        i_s_axi_arvalid,
    output logic             o_s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      o_s_axi_rdata,
    output logic [1:0]       o_s_axi_rresp,
    output logic             o_s_axi_rvalid,
    input  wire logic        i_s_axi_rready,
    // infrared pin and interrupt
    output logic             o_ir_out,
    output logic             o_ir_oe,
    output logic             o_irq
);

    function automatic logic addr_mapped(input logic [7:0] a);
        case (a)
            ir_mod_pkg::OFF_OUT_CTRL, ir_mod_pkg::OFF_MOD_STAT,
            ir_mod_pkg::OFF_MARK_HIGH, ir_mod_pkg::OFF_MARK_LOW,
            ir_mod_pkg::OFF_SPACE_HIGH, ir_mod_pkg::OFF_SPACE_LOW,
            ir_mod_pkg::OFF_CARR_HI_P, ir_mod_pkg::OFF_CARR_LO_P,
            ir_mod_pkg::OFF_CARR_HI_S, ir_mod_pkg::OFF_CARR_LO_S: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    endfunction

    // one module tick every 1, 2, 4 or 8 bus clocks
    function automatic logic presc_tick(input logic [2:0] cnt, input logic [1:0] sel);
        case (sel)
            2'h0:    presc_tick = 1'b1;
            2'h1:    presc_tick = cnt[0];
            2'h2:    presc_tick = &cnt[1:0];
            default: presc_tick = &cnt;
        endcase
    endfunction

    // bus state
    logic [7:0]  aw_addr_reg,  aw_addr_next;
    logic        aw_full_reg,  aw_full_next;
    logic [7:0]  w_data_reg,   w_data_next;
    logic        w_lane_reg,   w_lane_next;
    logic        w_full_reg,   w_full_next;
    logic        bvalid_reg,   bvalid_next;
    logic [1:0]  bresp_reg,    bresp_next;
    logic        arready_reg,  arready_next;
    logic        rvalid_reg,   rvalid_next;
    logic [31:0] rdata_reg,    rdata_next;
    logic [1:0]  rresp_reg,    rresp_next;
    // ready copies of the full flags, held full in reset so nothing is taken before ready shows
    logic        aw_full_reg_q;
    logic        w_full_reg_q;

    // software registers
    ir_mod_pkg::out_ctrl_t out_ctrl_reg, out_ctrl_next;
    ir_mod_pkg::mod_ctrl_t mod_ctrl_reg, mod_ctrl_next;
    logic [15:0] mark_buf_reg,  mark_buf_next;
    logic [15:0] space_buf_reg, space_buf_next;
    logic [7:0]  carr_hi_p_reg, carr_hi_p_next;
    logic [7:0]  carr_lo_p_reg, carr_lo_p_next;
    logic [7:0]  carr_hi_s_reg, carr_hi_s_next;
    logic [7:0]  carr_lo_s_reg, carr_lo_s_next;
    logic        end_of_cycle_flag_reg,      end_of_cycle_flag_next;
    logic        end_of_cycle_flag_armed_reg, end_of_cycle_flag_armed_next;

    // modulator engine
    ir_mod_pkg::mod_state_t state_reg, state_next;
    logic [2:0]  div_cnt_reg,   div_cnt_next;
    logic [7:0]  carr_cnt_reg,  carr_cnt_next;
    logic        carr_lvl_reg,  carr_lvl_next;
    logic [15:0] mod_cnt_reg,   mod_cnt_next;
    logic [15:0] space_per_reg, space_per_next;
    logic        sec_sel_reg,   sec_sel_next;
    logic        exsp_reg,      exsp_next;
    logic        ir_out_reg,    ir_out_next;
    logic        ir_oe_reg,     ir_oe_next;
    logic        irq_reg,       irq_next;

    logic        wr_fire;
    logic        rd_fire;
    logic        start_evt;
    logic        cycle_end;

    assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
    assign rd_fire = i_s_axi_arvalid && arready_reg;

    // ---------------- bus slave ----------------
    always_comb begin
        aw_addr_next = aw_addr_reg;
        aw_full_next = aw_full_reg;
        w_data_next  = w_data_reg;
        w_lane_next  = w_lane_reg;
        w_full_next  = w_full_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        arready_next = arready_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (i_s_axi_awvalid && !aw_full_reg_q) begin
            aw_addr_next = i_s_axi_awaddr;
            aw_full_next = 1'b1;
        end
        if (i_s_axi_wvalid && !w_full_reg_q) begin
            w_data_next = i_s_axi_wdata[7:0];
            w_lane_next = i_s_axi_wstrb[0];
            w_full_next = 1'b1;
        end
        if (wr_fire) begin
            aw_full_next = 1'b0;
            w_full_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = addr_mapped(aw_addr_reg) ? ir_mod_pkg::RESP_OKAY
                                                    : ir_mod_pkg::RESP_DECERR;
        end
        if (bvalid_reg && i_s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (rd_fire) begin
            arready_next = 1'b0;
            rvalid_next  = 1'b1;
            rresp_next   = addr_mapped(i_s_axi_araddr) ? ir_mod_pkg::RESP_OKAY
                                                       : ir_mod_pkg::RESP_DECERR;
            case (i_s_axi_araddr)
                ir_mod_pkg::OFF_OUT_CTRL:   rdata_next = {24'h000000, out_ctrl_reg, 5'h00};
                ir_mod_pkg::OFF_MOD_STAT:   rdata_next = {24'h000000, end_of_cycle_flag_reg, mod_ctrl_reg};
                ir_mod_pkg::OFF_MARK_HIGH:  rdata_next = {24'h000000, mark_buf_reg[15:8]};
                ir_mod_pkg::OFF_MARK_LOW:   rdata_next = {24'h000000, mark_buf_reg[7:0]};
                ir_mod_pkg::OFF_SPACE_HIGH: rdata_next = {24'h000000, space_buf_reg[15:8]};
                ir_mod_pkg::OFF_SPACE_LOW:  rdata_next = {24'h000000, space_buf_reg[7:0]};
                ir_mod_pkg::OFF_CARR_HI_P:  rdata_next = {24'h000000, carr_hi_p_reg};
                ir_mod_pkg::OFF_CARR_LO_P:  rdata_next = {24'h000000, carr_lo_p_reg};
                ir_mod_pkg::OFF_CARR_HI_S:  rdata_next = {24'h000000, carr_hi_s_reg};
                ir_mod_pkg::OFF_CARR_LO_S:  rdata_next = {24'h000000, carr_lo_s_reg};
                default:                    rdata_next = 32'h00000000;
            endcase
        end
        if (rvalid_reg && i_s_axi_rready) begin
            rvalid_next  = 1'b0;
            arready_next = 1'b1;
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            aw_addr_reg <= 8'h00;
            aw_full_reg <= 1'b0;
            w_data_reg  <= 8'h00;
            w_lane_reg  <= 1'b0;
            w_full_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'h0;
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h00000000;
            rresp_reg   <= 2'h0;
            aw_full_reg_q <= 1'b1;
            w_full_reg_q  <= 1'b1;
        end else begin
            aw_addr_reg <= aw_addr_next;
            aw_full_reg <= aw_full_next;
            w_data_reg  <= w_data_next;
            w_lane_reg  <= w_lane_next;
            w_full_reg  <= w_full_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            arready_reg <= arready_next || (!arready_reg && !rvalid_reg);
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
            aw_full_reg_q <= aw_full_next;
            w_full_reg_q  <= w_full_next;
        end
    end

    // ---------------- register file and flag ----------------
    always_comb begin
        logic wr_en;
        logic low_access;
        wr_en = wr_fire && w_lane_reg;
        low_access = 1'b0;
        out_ctrl_next   = out_ctrl_reg;
        mod_ctrl_next   = mod_ctrl_reg;
        mark_buf_next   = mark_buf_reg;
        space_buf_next  = space_buf_reg;
        carr_hi_p_next  = carr_hi_p_reg;
        carr_lo_p_next  = carr_lo_p_reg;
        carr_hi_s_next  = carr_hi_s_reg;
        carr_lo_s_next  = carr_lo_s_reg;
        end_of_cycle_flag_next       = end_of_cycle_flag_reg;
        end_of_cycle_flag_armed_next = end_of_cycle_flag_armed_reg;
        if (wr_en) begin
            case (aw_addr_reg)
                ir_mod_pkg::OFF_OUT_CTRL:   out_ctrl_next        = w_data_next_field(w_data_reg);
                ir_mod_pkg::OFF_MOD_STAT:   mod_ctrl_next        = w_data_reg[6:0];
                ir_mod_pkg::OFF_MARK_HIGH:  mark_buf_next[15:8]  = w_data_reg;
                ir_mod_pkg::OFF_MARK_LOW:   mark_buf_next[7:0]   = w_data_reg;
                ir_mod_pkg::OFF_SPACE_HIGH: space_buf_next[15:8] = w_data_reg;
                ir_mod_pkg::OFF_SPACE_LOW:  space_buf_next[7:0]  = w_data_reg;
                ir_mod_pkg::OFF_CARR_HI_P:  carr_hi_p_next       = w_data_reg;
                ir_mod_pkg::OFF_CARR_LO_P:  carr_lo_p_next       = w_data_reg;
                ir_mod_pkg::OFF_CARR_HI_S:  carr_hi_s_next       = w_data_reg;
                ir_mod_pkg::OFF_CARR_LO_S:  carr_lo_s_next       = w_data_reg;
                default: ;
            endcase
        end
        // clearing takes a status read first, then any access to a low period byte
        low_access = (wr_fire && (aw_addr_reg == ir_mod_pkg::OFF_MARK_LOW ||
                                  aw_addr_reg == ir_mod_pkg::OFF_SPACE_LOW)) ||
                     (rd_fire && (i_s_axi_araddr == ir_mod_pkg::OFF_MARK_LOW ||
                                  i_s_axi_araddr == ir_mod_pkg::OFF_SPACE_LOW));
        if (rd_fire && i_s_axi_araddr == ir_mod_pkg::OFF_MOD_STAT && end_of_cycle_flag_reg) begin
            end_of_cycle_flag_armed_next = 1'b1;
        end
        if (low_access && end_of_cycle_flag_armed_reg) begin
            end_of_cycle_flag_next       = 1'b0;
            end_of_cycle_flag_armed_next = 1'b0;
        end
        // a new event wins over a clear in the same cycle and must be read again
        if (start_evt || (cycle_end && mod_ctrl_reg.modulator_enable)) begin
            end_of_cycle_flag_next       = 1'b1;
            end_of_cycle_flag_armed_next = 1'b0;
        end
    end

    function automatic ir_mod_pkg::out_ctrl_t w_data_next_field(input logic [7:0] d);
        w_data_next_field = d[7:5];
    endfunction

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            out_ctrl_reg   <= ir_mod_pkg::OUT_CTRL_RESET;
            mod_ctrl_reg   <= ir_mod_pkg::MOD_CTRL_RESET;
            mark_buf_reg   <= 16'h0000;
            space_buf_reg  <= 16'h0000;
            carr_hi_p_reg  <= 8'h00;
            carr_lo_p_reg  <= 8'h00;
            carr_hi_s_reg  <= 8'h00;
            carr_lo_s_reg  <= 8'h00;
            end_of_cycle_flag_reg       <= 1'b0;
            end_of_cycle_flag_armed_reg <= 1'b0;
        end else begin
            out_ctrl_reg   <= out_ctrl_next;
            mod_ctrl_reg   <= mod_ctrl_next;
            mark_buf_reg   <= mark_buf_next;
            space_buf_reg  <= space_buf_next;
            carr_hi_p_reg  <= carr_hi_p_next;
            carr_lo_p_reg  <= carr_lo_p_next;
            carr_hi_s_reg  <= carr_hi_s_next;
            carr_lo_s_reg  <= carr_lo_s_next;
            end_of_cycle_flag_reg       <= end_of_cycle_flag_next;
            end_of_cycle_flag_armed_reg <= end_of_cycle_flag_armed_next;
        end
    end

    // ---------------- carrier generator and modulator ----------------
    // prescaler is live: changing it mid-transmission shortens or stretches one tick
    assign start_evt = (state_reg == ir_mod_pkg::ST_IDLE) && mod_ctrl_reg.modulator_enable;
    assign cycle_end = (state_reg == ir_mod_pkg::ST_SPACE) &&
                       presc_tick(div_cnt_reg, mod_ctrl_reg.clock_prescaler_field) &&
                       (mod_cnt_reg == space_per_reg);

    always_comb begin
        logic       tick;
        logic [7:0] carr_lim;
        logic       mod_out;
        logic       lvl;
        carr_lim      = 8'h00;
        mod_out       = 1'b0;
        lvl           = 1'b0;
        tick          = presc_tick(div_cnt_reg, mod_ctrl_reg.clock_prescaler_field);
        state_next    = state_reg;
        div_cnt_next  = div_cnt_reg + 3'h1;
        carr_cnt_next = carr_cnt_reg;
        carr_lvl_next = carr_lvl_reg;
        mod_cnt_next  = mod_cnt_reg;
        space_per_next = space_per_reg;
        sec_sel_next  = sec_sel_reg;
        exsp_next     = exsp_reg || mod_ctrl_reg.extended_space_enable;
        if (sec_sel_reg && mod_ctrl_reg.freq_shift_mode_select) begin
            carr_lim = carr_lvl_reg ? carr_hi_s_reg : carr_lo_s_reg;
        end else begin
            carr_lim = carr_lvl_reg ? carr_hi_p_reg : carr_lo_p_reg;
        end
        if (state_reg != ir_mod_pkg::ST_IDLE && tick) begin
            if (mod_ctrl_reg.baseband_enable) begin
                carr_lvl_next = 1'b1;
                carr_cnt_next = 8'h00;
            end else if (carr_cnt_reg + 8'h01 >= carr_lim) begin
                carr_lvl_next = !carr_lvl_reg;
                carr_cnt_next = 8'h00;
            end else begin
                carr_cnt_next = carr_cnt_reg + 8'h01;
            end
        end
        case (state_reg)
            ir_mod_pkg::ST_IDLE: begin
                exsp_next    = mod_ctrl_reg.extended_space_enable;
                div_cnt_next = 3'h0;
                if (start_evt) begin
                    state_next     = ir_mod_pkg::ST_MARK;
                    mod_cnt_next   = mark_buf_reg;
                    space_per_next = space_buf_reg;
                    carr_cnt_next  = 8'h00;
                    carr_lvl_next  = 1'b1;
                    sec_sel_next   = 1'b0;
                end
            end
            ir_mod_pkg::ST_MARK: begin
                if (tick) begin
                    if (mod_cnt_reg <= 16'h0001) begin
                        state_next   = ir_mod_pkg::ST_SPACE;
                        mod_cnt_next = 16'h0000;
                    end else begin
                        mod_cnt_next = mod_cnt_reg - 16'h0001;
                    end
                end
            end
            ir_mod_pkg::ST_SPACE: begin
                if (cycle_end) begin
                    exsp_next = mod_ctrl_reg.extended_space_enable;
                    if (mod_ctrl_reg.modulator_enable) begin
                        state_next     = ir_mod_pkg::ST_MARK;
                        mod_cnt_next   = mark_buf_reg;
                        space_per_next = space_buf_reg;
                        if (mod_ctrl_reg.freq_shift_mode_select) begin
                            sec_sel_next = !sec_sel_reg;
                        end
                    end else begin
                        state_next = ir_mod_pkg::ST_IDLE;
                    end
                end else if (tick) begin
                    mod_cnt_next = mod_cnt_reg + 16'h0001;
                end
            end
            default: state_next = ir_mod_pkg::ST_IDLE;
        endcase
        // output is carrier during an unsuppressed mark, low in space, and the latch bit when modulator_enable is off
        mod_out = (state_reg == ir_mod_pkg::ST_MARK) && !exsp_reg &&
                  !mod_ctrl_reg.extended_space_enable && carr_lvl_reg;
        lvl = mod_ctrl_reg.modulator_enable ? mod_out : out_ctrl_reg.ir_latch_bit;
        ir_out_next = out_ctrl_reg.output_polarity ? lvl : !lvl;
        ir_oe_next  = out_ctrl_reg.ir_pin_enable;
        irq_next    = end_of_cycle_flag_next && mod_ctrl_next.end_of_cycle_irq_enable;
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg     <= ir_mod_pkg::ST_IDLE;
            div_cnt_reg   <= 3'h0;
            carr_cnt_reg  <= 8'h00;
            carr_lvl_reg  <= 1'b0;
            mod_cnt_reg   <= 16'h0000;
            space_per_reg <= 16'h0000;
            sec_sel_reg   <= 1'b0;
            exsp_reg      <= 1'b0;
            ir_out_reg    <= 1'b0;
            ir_oe_reg     <= 1'b0;
            irq_reg       <= 1'b0;
        end else begin
            state_reg     <= state_next;
            div_cnt_reg   <= div_cnt_next;
            carr_cnt_reg  <= carr_cnt_next;
            carr_lvl_reg  <= carr_lvl_next;
            mod_cnt_reg   <= mod_cnt_next;
            space_per_reg <= space_per_next;
            sec_sel_reg   <= sec_sel_next;
            exsp_reg      <= exsp_next;
            ir_out_reg    <= ir_out_next;
            ir_oe_reg     <= ir_oe_next;
            irq_reg       <= irq_next;
        end
    end

    assign o_s_axi_awready = !aw_full_reg_q;
    assign o_s_axi_wready  = !w_full_reg_q;
    assign o_s_axi_bresp   = bresp_reg;
    assign o_s_axi_bvalid  = bvalid_reg;
    assign o_s_axi_arready = arready_reg;
    assign o_s_axi_rdata   = rdata_reg;
    assign o_s_axi_rresp   = rresp_reg;
    assign o_s_axi_rvalid  = rvalid_reg;
    assign o_ir_out        = ir_out_reg;
    assign o_ir_oe         = ir_oe_reg;
    assign o_irq           = irq_reg;

endmodule // ir_carrier_modulator

// [core/ir_mod_pkg.sv]
package ir_mod_pkg;

    // register byte offsets on the AXI4-Lite map
    localparam logic [7:0] OFF_OUT_CTRL   = 8'h00;
    localparam logic [7:0] OFF_MOD_STAT   = 8'h04;
    localparam logic [7:0] OFF_MARK_HIGH  = 8'h08;
    localparam logic [7:0] OFF_MARK_LOW   = 8'h0C;
    localparam logic [7:0] OFF_SPACE_HIGH = 8'h10;
    localparam logic [7:0] OFF_SPACE_LOW  = 8'h14;
    localparam logic [7:0] OFF_CARR_HI_P  = 8'h18;
    localparam logic [7:0] OFF_CARR_LO_P  = 8'h1C;
    localparam logic [7:0] OFF_CARR_HI_S  = 8'h20;
    localparam logic [7:0] OFF_CARR_LO_S  = 8'h24;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ir_output_control: bit 7 latch, bit 6 polarity, bit 5 pin enable
    typedef struct packed {
        logic ir_latch_bit;
        logic output_polarity;
        logic ir_pin_enable;
    } out_ctrl_t;

    // modulator_status_control bits 6..0; bit 7 is the end-of-cycle flag
    typedef struct packed {
        logic [1:0] clock_prescaler_field;
        logic       extended_space_enable;
        logic       baseband_enable;
        logic       freq_shift_mode_select;
        logic       end_of_cycle_irq_enable;
        logic       modulator_enable;
    } mod_ctrl_t;

    localparam out_ctrl_t OUT_CTRL_RESET = 3'h0;
    localparam mod_ctrl_t MOD_CTRL_RESET = 7'h00;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_MARK  = 3'b010,
        ST_SPACE = 3'b100
    } mod_state_t;

endpackage

// [testbench/ir_emitter_model.sv]
`timescale 1ns/1ps
module ir_emitter_model (
    input  wire logic i_level,
    input  wire logic i_drive,
    output logic      o_lit
);
    // a released pin is pulled down, so the emitter stays dark
    assign o_lit = i_drive ? i_level : 1'b0;
endmodule // ir_emitter_model

// [testbench/ir_mod_props.sv]
`timescale 1ns/1ps
module ir_mod_props (
    input wire logic        i_mclk, i_sys_rst, i_s_axi_awvalid, i_s_axi_wvalid,
    input wire logic        i_s_axi_arvalid, i_s_axi_bready, i_s_axi_rready,
    input wire logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_arready,
    input wire logic        o_s_axi_bvalid, o_s_axi_rvalid, o_ir_oe, o_irq,
    input wire logic [1:0]  o_s_axi_bresp,
    input wire logic [31:0] o_s_axi_rdata
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    a_reset_pin_off: assert property ($fell(i_sys_rst) |-> !o_ir_oe && !o_irq)
        else $error("pin or irq active after reset");
    a_oe_by_write: assert property ($changed(o_ir_oe) |-> $past(o_s_axi_bvalid))
        else $error("pin enable moved without a write");
    // only a bus access can clear the flag, so a quiet bus keeps the request up
    a_irq_held: assert property (o_irq && !i_s_axi_awvalid && !i_s_axi_arvalid &&
        !$past(i_s_axi_awvalid) && !$past(i_s_axi_arvalid) && !$past(i_s_axi_arvalid, 2)
        |=> o_irq) else $error("irq dropped without access");
    a_bvalid_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
        o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("write response dropped");
    a_rvalid_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
        o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read data dropped");
    a_write_answer: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid
        && o_s_axi_wready |-> ##2 o_s_axi_bvalid) else $error("write response late");
    a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
        else $error("read data late");
    a_rdata_upper: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    c_irq: cover property ($rose(o_irq));
    c_decerr: cover property (o_s_axi_bvalid && o_s_axi_bresp == 2'h3);
    c_pin_on: cover property ($rose(o_ir_oe));
endmodule // ir_mod_props

// [testbench/tb_ir_carrier_modulator.sv]
`timescale 1ns/1ps
module tb_ir_carrier_modulator;
    logic        i_mclk = 1'b0, i_sys_rst = 1'b1, lit, p;
    logic [7:0]  i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
    logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata, rd_data;
    logic [3:0]  i_s_axi_wstrb = 4'hF;
    logic        i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
    logic        i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0, o_s_axi_awready;
    logic        o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
    logic        o_ir_out, o_ir_oe, o_irq;
    logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, resp;
    int          n_fail = 0, n_tests = 0, cyc = 0;
    always #20 i_mclk = ~i_mclk;
    ir_carrier_modulator u_ir_carrier_modulator (.i_mclk, .i_sys_rst, .i_s_axi_awaddr,
        .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid,
        .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr,
        .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid,
        .i_s_axi_rready, .o_ir_out, .o_ir_oe, .o_irq);
    ir_emitter_model u_ir_emitter_model (.i_level(o_ir_out), .i_drive(o_ir_oe), .o_lit(lit));
    task automatic conclude();
        if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= {24'h0, d};
        i_s_axi_awvalid <= 1'b1;
        i_s_axi_wvalid <= 1'b1;
        i_s_axi_bready <= 1'b1;
        do begin
            @(posedge i_mclk);
            if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
            if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
        end while (o_s_axi_bvalid !== 1'b1);
        resp = o_s_axi_bresp;
        i_s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge i_mclk);
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1'b1;
        i_s_axi_rready <= 1'b1;
        do begin
            @(posedge i_mclk);
            if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
        end while (o_s_axi_rvalid !== 1'b1);
        resp = o_s_axi_rresp;
        i_s_axi_rready <= 1'b0;
        chk(what, exp, o_s_axi_rdata);
    endtask
    // measures one mark and the following space in bus clock cycles
    task automatic pulse(input int hi, input int lo);
        int n;
        while (o_ir_out !== 1'b0) @(posedge i_mclk);
        while (o_ir_out !== 1'b1) @(posedge i_mclk);
        for (n = 0; o_ir_out === 1'b1; n++) @(posedge i_mclk);
        chk("mark length", hi, n);
        for (n = 0; o_ir_out === 1'b0; n++) @(posedge i_mclk);
        chk("space length", lo, n);
    endtask
    task automatic reset_values();
        chk("pin enable", 32'h0, {31'h0, o_ir_oe});
        for (int i = 0; i < 10; i++) rd(8'(i * 4), 32'h0, "reset value");
        rd(8'h28, 32'h0, "unmapped read");
        chk("read resp", 32'h3, {30'h0, resp});
        wr(8'h28, 8'h5A);
        chk("write resp", 32'h3, {30'h0, resp});
        i_s_axi_wstrb <= 4'h0;
        wr(8'h08, 8'h5A);
        i_s_axi_wstrb <= 4'hF;
        chk("masked write resp", 32'h0, {30'h0, resp});
        rd(8'h08, 32'h0, "masked write");
    endtask
    task automatic pin_control();
        logic [7:0] cfg [5] = '{8'h80, 8'hA0, 8'hE0, 8'h60, 8'h20};
        logic [1:0] pin [5] = '{2'b00, 2'b10, 2'b11, 2'b10, 2'b11};
        for (int i = 0; i < 5; i++) begin
            wr(8'h00, cfg[i]);
            @(posedge i_mclk);
            chk("pin drive and level", {30'h0, pin[i]}, {30'h0, o_ir_oe, lit});
            rd(8'h00, {24'h0, cfg[i]}, "output control");
        end
    endtask
    // counts pin level changes over four plain modulation periods
    task automatic count_toggles(output int n);
        n = 0;
        p = o_ir_out;
        repeat (132) begin
            @(posedge i_mclk);
            if (o_ir_out !== p) n++;
            p = o_ir_out;
        end
    endtask
    task automatic modulation();
        int n;
        wr(8'h00, 8'h60);
        wr(8'h0C, 8'h10);
        wr(8'h14, 8'h10);
        wr(8'h04, 8'h0B);
        for (n = 0; o_irq !== 1'b1 && n < 10; n++) @(posedge i_mclk);
        rd(8'h04, 32'h8B, "status");
        chk("irq", 32'h1, {31'h0, o_irq});
        rd(8'h0C, 32'h10, "mark low");
        repeat (2) @(posedge i_mclk);
        chk("irq after clear", 32'h0, {31'h0, o_irq});
        wr(8'h04, 8'h0A);
        wr(8'h04, 8'h0B);
        chk("irq at re-enable", 32'h0, {31'h0, o_irq});
        repeat (20) @(posedge i_mclk);
        chk("irq at cycle end", 32'h1, {31'h0, o_irq});
        for (int d = 0; d < 5; d++) begin
            wr(8'h04, 8'h0A);
            repeat (300) @(posedge i_mclk);
            wr(8'h04, {1'b0, 2'(d % 4), 5'h0B});
            pulse(16 << (d % 4), 17 << (d % 4));
        end
        wr(8'h04, 8'h1B);
        wr(8'h00, 8'hE0);
        repeat (40) @(posedge i_mclk);
        n = 0;
        repeat (100) begin
            @(posedge i_mclk);
            if (o_ir_out !== 1'b0) n++;
        end
        chk("marks in extended space", 32'h0, n);
        wr(8'h00, 8'h60);
        wr(8'h04, 8'h0B);
        pulse(16, 17);
        wr(8'h04, 8'h0A);
        repeat (300) @(posedge i_mclk);
        wr(8'h18, 8'h04);
        wr(8'h1C, 8'h04);
        wr(8'h04, 8'h03);
        count_toggles(n);
        chk("carrier toggling", 32'h1, {31'h0, n > 12});
        wr(8'h04, 8'h02);
        repeat (300) @(posedge i_mclk);
        wr(8'h20, 8'h01);
        wr(8'h24, 8'h01);
        wr(8'h04, 8'h07);
        count_toggles(n);
        chk("shifted carrier toggling", 32'h1, {31'h0, n > 28});
    endtask
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        repeat (3) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        @(posedge i_mclk);
        reset_values();
        pin_control();
        modulation();
        conclude();
    end
endmodule // tb_ir_carrier_modulator
bind ir_carrier_modulator ir_mod_props u_ir_mod_props (.i_mclk, .i_sys_rst, .i_s_axi_awvalid,
    .i_s_axi_wvalid, .i_s_axi_arvalid, .i_s_axi_bready, .i_s_axi_rready, .o_s_axi_awready,
    .o_s_axi_wready, .o_s_axi_arready, .o_s_axi_bvalid, .o_s_axi_rvalid, .o_ir_oe, .o_irq,
    .o_s_axi_bresp, .o_s_axi_rdata);
